// ==== include/pnpcr_pkg.sv ====
// Constants, types and register indices for the card configuration registers.
// Assumes a classic Wishbone host and one clock shared with the ISA side.
//
// Overview of operation
// - Control bit 1 sends card to wait-for-key; select number and devices kept.
// - Control bit 2 clears the card select number to zero.
// - Matching wake in sleep: zero data goes to isolation, nonzero to configuration.
// - Every wake rewinds the resource byte pointer to the first byte.
// - Each resource data read returns the next byte and advances.
// - Status bit 0 reads one only when the next resource byte is ready.
// - Select number register stores written value and reads it back.
// - Device number register routes per-device register accesses.
// - Activate and range check act only on the selected device.
// - With a single device the device number reads fixed zero.
// - Each device has its own activate bit 0 enabling it.
// - Reserved activate and range check bits read zero.
// - Range check bit 1 enables check, effective only while inactive.
// - Checked reads of the device range return 0055h or 00AAh.
// - Descriptor 0 base address high and low bytes, read/write.
// - Descriptor 1 base address high and low bytes, read/write.
// - Control bits self clear and the control register reads zero.
// - Control bit 0 resets devices and configuration, keeping select number.

package pnpcr_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h02;
  localparam logic [7:0] IDX_WAKE = 8'h03;
  localparam logic [7:0] IDX_RSRC = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_CSN = 8'h06;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_KEY = 8'h08;
  localparam logic [7:0] IDX_STATE = 8'h09;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_CHK = 8'h31;
  localparam logic [7:0] IDX_B0_HI = 8'h60;
  localparam logic [7:0] IDX_B0_LO = 8'h61;
  localparam logic [7:0] IDX_B1_HI = 8'h62;
  localparam logic [7:0] IDX_B1_LO = 8'h63;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_WAIT_KEY = 1;
  localparam int CTRL_CSN_CLR = 2;
  localparam int CHK_PATTERN = 0;
  localparam int CHK_ENABLE = 1;

  // ----------------------------------------------------------------
  // Reset values and fixed data
  // ----------------------------------------------------------------
  localparam logic [7:0] CSN_RESET = 8'h00;
  localparam logic [7:0] LDN_RESET = 8'h00;
  localparam logic ACT_RESET = 1'b0;
  localparam logic [1:0] CHK_RESET = 2'h0;
  localparam logic [15:0] BASE_RESET = 16'h0000;
  localparam logic [15:0] CHK_PASS_DATA = 16'h0055;
  localparam logic [15:0] CHK_FAIL_DATA = 16'h00AA;
  localparam logic [15:0] IO_SPAN = 16'h0008;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int LD_COUNT = 2;
  localparam int LD_W = 1;
  localparam int RSRC_AW = 5;

  // ----------------------------------------------------------------
  // Card states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT_KEY = 2'b00,
    ST_SLEEP = 2'b01,
    ST_ISOLATE = 2'b10,
    ST_CONFIG = 2'b11
  } pnpcr_state_t;

endpackage

// ==== hw/pnpcr_rsrc_rom.sv ====
// Resource information bytes, read one at a time.
// Assumes the address is stable for one clock before data is used.
`timescale 1ns/1ps

module pnpcr_rsrc_rom (
  input wire logic clk_i,
  input wire logic [pnpcr_pkg::RSRC_AW-1:0] addr_i,
  output logic [7:0] data_o
);
  import pnpcr_pkg::*;

  // ----------------------------------------------------------------
  // Table, identity bytes are arbitrary
  // ----------------------------------------------------------------
  logic [7:0] rom_word;

  always_comb begin
    case (addr_i)
      5'h00: rom_word = 8'h12;
      5'h01: rom_word = 8'h34;
      5'h02: rom_word = 8'h56;
      5'h03: rom_word = 8'h78;
      5'h04: rom_word = 8'h0A;
      5'h05: rom_word = 8'h15;
      5'h06: rom_word = 8'h47;
      5'h07: rom_word = 8'h01;
      5'h08: rom_word = 8'h00;
      5'h09: rom_word = 8'h00;
      5'h0A: rom_word = 8'h79;
      default: rom_word = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    data_o <= rom_word;
  end

endmodule

// ==== hw/pnpcr_top.sv ====
// Card and logical device configuration registers on a Wishbone slave.
// Assumes ISA I/O decode inputs come from logic on the same clock.
`timescale 1ns/1ps

module pnpcr_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  output logic [pnpcr_pkg::LD_COUNT-1:0] io_sel_o,
  output logic io_chk_valid_o,
  output logic [15:0] io_chk_data_o,
  output logic [pnpcr_pkg::LD_COUNT-1:0] ld_active_o,
  output pnpcr_pkg::pnpcr_state_t card_state_o
);
  import pnpcr_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;

  wire logic req = wb_cyc_i & wb_stb_i;
  wire logic take = req & ack_reg;
  wire logic wr = take & wb_we_i & wb_sel_i[0];
  wire logic rd = take & ~wb_we_i;
  wire logic [7:0] idx = wb_adr_i[9:2];
  wire logic [7:0] wdat = wb_dat_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ----------------------------------------------------------------
  // Write and resource read decode
  // ----------------------------------------------------------------
  wire logic wr_ctrl = wr & (idx == IDX_CTRL);
  wire logic wr_wake = wr & (idx == IDX_WAKE);
  wire logic wr_csn = wr & (idx == IDX_CSN);
  wire logic wr_ldn = wr & (idx == IDX_LDN);
  wire logic wr_key = wr & (idx == IDX_KEY);
  wire logic rd_rsrc = rd & (idx == IDX_RSRC);
  wire logic soft_rst = wr_ctrl & wdat[CTRL_SOFT_RST];
  wire logic go_wait = wr_ctrl & wdat[CTRL_WAIT_KEY];
  wire logic csn_clr = wr_ctrl & wdat[CTRL_CSN_CLR];

  // ----------------------------------------------------------------
  // Card state and select number
  // ----------------------------------------------------------------
  pnpcr_state_t state_reg;
  pnpcr_state_t state_next;
  logic [7:0] csn_reg;
  logic [7:0] ldn_reg;

  wire logic wake_match = wr_wake & (wdat == csn_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT_KEY: begin
        if (wr_key) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_match) begin
          state_next = (wdat == 8'h00) ? ST_ISOLATE : ST_CONFIG;
        end
      end
      ST_ISOLATE, ST_CONFIG: begin
        if (wr_wake & ~wake_match) begin
          state_next = ST_SLEEP;
        end
      end
      default: state_next = ST_WAIT_KEY;
    endcase
    if (go_wait) begin
      state_next = ST_WAIT_KEY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_WAIT_KEY;
      csn_reg <= CSN_RESET;
    end else begin
      state_reg <= state_next;
      if (csn_clr) begin
        csn_reg <= 8'h00;
      end else if (wr_csn) begin
        csn_reg <= wdat;
      end
    end
  end

  // Soft reset returns the device number but keeps the select number
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      ldn_reg <= LDN_RESET;
    end else if (wr_ldn && LD_COUNT > 1) begin
      ldn_reg <= wdat;
    end
  end

  assign card_state_o = state_reg;

  // ----------------------------------------------------------------
  // Resource data pointer and ready flag
  // ----------------------------------------------------------------
  logic [RSRC_AW-1:0] ptr_reg;
  logic rdy_reg;
  logic [7:0] rsrc_byte;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      if (wr_wake) begin
        ptr_reg <= '0;
      end else if (rd_rsrc) begin
        ptr_reg <= ptr_reg + 1'b1;
      end
      rdy_reg <= ~(wr_wake | rd_rsrc);
    end
  end

  pnpcr_rsrc_rom u_rom (
    .clk_i (clk_i),
    .addr_i (ptr_reg),
    .data_o (rsrc_byte)
  );

  // ----------------------------------------------------------------
  // Logical devices
  // ----------------------------------------------------------------
  wire logic ld_ok = (ldn_reg < 8'(LD_COUNT));
  wire logic [LD_W-1:0] ld_sel = ldn_reg[LD_W-1:0];
  wire logic [LD_COUNT-1:0] act_vec;
  wire logic [2*LD_COUNT-1:0] chk_flat;
  wire logic [16*LD_COUNT-1:0] b0_flat;
  wire logic [16*LD_COUNT-1:0] b1_flat;
  wire logic [LD_COUNT-1:0] chk_hit;
  wire logic [LD_COUNT-1:0] chk_pass;

  genvar d;
  generate
    for (d = 0; d < LD_COUNT; d = d + 1) begin : g_ld
      logic act_reg;
      logic [1:0] chk_reg;
      logic [15:0] b0_reg;
      logic [15:0] b1_reg;
      wire logic mine = wr & ld_ok & (ld_sel == LD_W'(d));
      wire logic chk_on = chk_reg[CHK_ENABLE] & ~act_reg;
      wire logic [15:0] off0 = io_addr_i - b0_reg;
      wire logic [15:0] off1 = io_addr_i - b1_reg;
      wire logic in_rng = (off0 < IO_SPAN) | (off1 < IO_SPAN);

      always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
          act_reg <= ACT_RESET;
          chk_reg <= CHK_RESET;
          b0_reg <= BASE_RESET;
          b1_reg <= BASE_RESET;
        end else if (mine) begin
          if (idx == IDX_ACT) begin
            act_reg <= wdat[0];
          end
          if (idx == IDX_CHK) begin
            chk_reg <= wdat[1:0];
          end
          if (idx == IDX_B0_HI) begin
            b0_reg[15:8] <= wdat;
          end
          if (idx == IDX_B0_LO) begin
            b0_reg[7:0] <= wdat;
          end
          if (idx == IDX_B1_HI) begin
            b1_reg[15:8] <= wdat;
          end
          if (idx == IDX_B1_LO) begin
            b1_reg[7:0] <= wdat;
          end
        end
      end

      assign act_vec[d] = act_reg;
      assign chk_flat[2*d +: 2] = chk_reg;
      assign b0_flat[16*d +: 16] = b0_reg;
      assign b1_flat[16*d +: 16] = b1_reg;
      assign io_sel_o[d] = (act_reg | chk_on) & in_rng;
      assign chk_hit[d] = chk_on & in_rng;
      assign chk_pass[d] = chk_on & in_rng & chk_reg[CHK_PATTERN];

      act_other_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr & ~soft_rst & (idx == IDX_ACT) & (ldn_reg != 8'(d))) |=> $stable(act_reg))
        else $error("Activate changed for a device not selected");

      decode_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!act_reg && !chk_reg[CHK_ENABLE]) |-> !io_sel_o[d])
        else $error("Idle device decoded an address");
    end
  endgenerate

  assign ld_active_o = act_vec;

  // ----------------------------------------------------------------
  // Range check answer
  // ----------------------------------------------------------------
  logic chk_valid_reg;
  logic [15:0] chk_data_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_valid_reg <= 1'b0;
      chk_data_reg <= 16'h0000;
    end else begin
      chk_valid_reg <= io_rd_i & (|chk_hit);
      if (io_rd_i & (|chk_hit)) begin
        chk_data_reg <= (|chk_pass) ? CHK_PASS_DATA : CHK_FAIL_DATA;
      end
    end
  end

  assign io_chk_valid_o = chk_valid_reg;
  assign io_chk_data_o = chk_data_reg;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic sel_act = ld_ok & act_vec[ld_sel];
  wire logic [1:0] sel_chk = ld_ok ? chk_flat[2*ld_sel +: 2] : 2'h0;
  wire logic [15:0] sel_b0 = ld_ok ? b0_flat[16*ld_sel +: 16] : 16'h0000;
  wire logic [15:0] sel_b1 = ld_ok ? b1_flat[16*ld_sel +: 16] : 16'h0000;
  logic [7:0] rd_byte;

  always_comb begin
    case (idx)
      IDX_RSRC: rd_byte = rsrc_byte;
      IDX_STATUS: rd_byte = {7'h00, rdy_reg};
      IDX_CSN: rd_byte = csn_reg;
      IDX_LDN: rd_byte = (LD_COUNT > 1) ? ldn_reg : 8'h00;
      IDX_STATE: rd_byte = {6'h00, state_reg};
      IDX_ACT: rd_byte = {7'h00, sel_act};
      IDX_CHK: rd_byte = {6'h00, sel_chk};
      IDX_B0_HI: rd_byte = sel_b0[15:8];
      IDX_B0_LO: rd_byte = sel_b0[7:0];
      IDX_B1_HI: rd_byte = sel_b1[15:8];
      IDX_B1_LO: rd_byte = sel_b1[7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  assign dat_next = (req & ~ack_reg & ~wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle");

  wait_key_ret_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (go_wait & ~csn_clr) |=> (state_reg == ST_WAIT_KEY) && (csn_reg == $past(csn_reg)))
    else $error("Wait-for-key command lost state or select number");

  csn_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    csn_clr |=> (csn_reg == 8'h00))
    else $error("Select number not cleared");

  wake_config_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_match & (state_reg == ST_SLEEP) & (wdat != 8'h00) & ~go_wait) |=> (state_reg == ST_CONFIG))
    else $error("Matching wake did not enter configuration");

  wake_rewind_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_wake |=> (ptr_reg == '0) && !rdy_reg)
    else $error("Wake did not rewind resource pointer");

  rsrc_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_rsrc |=> (ptr_reg == $past(ptr_reg) + 1'b1))
    else $error("Resource pointer did not advance");

  ready_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_rsrc | wr_wake) |=> !rdy_reg ##1 (rdy_reg || $past(rd_rsrc | wr_wake)))
    else $error("Ready flag timing wrong");

  csn_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_csn & ~csn_clr) |=> (csn_reg == $past(wdat)))
    else $error("Select number write not stored");

  soft_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_rst & ~csn_clr & ~wr_csn) |=> (ldn_reg == LDN_RESET) && (ld_active_o == '0) && $stable(csn_reg))
    else $error("Soft reset wrong");

  chk_pattern_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_rd_i & (|chk_hit)) |=> io_chk_valid_o && (io_chk_data_o == ($past(|chk_pass) ? CHK_PASS_DATA : CHK_FAIL_DATA)))
    else $error("Range check answer wrong");

  isolate_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_match & (state_reg == ST_SLEEP) & (wdat == 8'h00)) |=> (state_reg == ST_ISOLATE))
    else $error("Matching zero wake did not enter isolation");

  csn_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd & (idx == IDX_CSN)) |-> (wb_dat_o == {24'h00_0000, csn_reg}))
    else $error("Select number read back wrong");

  act_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd & (idx == IDX_ACT)) |-> (wb_dat_o[7:1] == 7'h00))
    else $error("Activate reserved bits not zero");

  chk_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd & (idx == IDX_CHK)) |-> (wb_dat_o[7:2] == 6'h00))
    else $error("Range check reserved bits not zero");

  ctrl_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd & (idx == IDX_CTRL)) |-> (wb_dat_o == 32'h0000_0000))
    else $error("Control register read not zero");

  chk_origin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    io_chk_valid_o |-> $past(io_rd_i) && !(&$past(act_vec)))
    else $error("Range check answer without an inactive device");

  base0_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr & ~soft_rst & ld_ok & (idx == IDX_B0_LO)) |=> (sel_b0[7:0] == $past(wdat)))
    else $error("Descriptor 0 low byte not stored");

  base1_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr & ~soft_rst & ld_ok & (idx == IDX_B1_HI)) |=> (sel_b1[15:8] == $past(wdat)))
    else $error("Descriptor 1 high byte not stored");

endmodule

// ==== tb/pnpcr_host.sv ====
// Host model: Wishbone master cycles for the card configuration registers.
// Assumes a slave that acks every classic cycle within 50 clocks.
`timescale 1ns/1ps

module pnpcr_host (
  input wire logic clk_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [9:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  import pnpcr_pkg::*;
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 10'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    q = 8'h00;
    ok = 1'b0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h00_0000, d};
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        q = wb_dat_i[7:0];
        ok = 1'b1;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
  endtask

  // Resource byte after polling ready
  task automatic rsrc(output logic [7:0] q, output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    q = 8'h00;
    for (int n = 0; n < 20 && !ok; n++) begin
      xfer(1'b0, IDX_STATUS, 8'h00, s, ok);
      ok = ok && (s[0] === 1'b1);
    end
    if (ok) xfer(1'b0, IDX_RSRC, 8'h00, q, ok);
  endtask

  // Check off before activation
  task automatic activate(input logic [7:0] a, output bit ok);
    logic [7:0] q;
    xfer(1'b1, IDX_CHK, 8'h00, q, ok);
    if (ok) xfer(1'b1, IDX_ACT, a, q, ok);
  endtask
endmodule

// ==== tb/pnpcr_top_tb.sv ====
// Self-checking bench for the card configuration registers.
// Assumes the host model in pnpcr_host and a 100 MHz clock.
`timescale 1ns/1ps

module pnpcr_top_tb;
  import pnpcr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [9:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wd, wb_rd;
  logic [15:0] io_addr = 16'h0000;
  logic io_rd = 1'b0;
  logic [1:0] io_sel, ld_act;
  logic io_vld;
  logic [15:0] io_dat;
  pnpcr_state_t st;
  int n_fail = 0;
  int n_checks = 0;
  bit ok;
  logic [7:0] q, card_select_value;
  logic [7:0] b[0:10];
  logic [15:0] base[0:1][0:1];

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  pnpcr_host host (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wd), .wb_dat_i(wb_rd), .wb_ack_i(wb_ack));

  pnpcr_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .io_addr_i(io_addr), .io_rd_i(io_rd), .io_sel_o(io_sel),
    .io_chk_valid_o(io_vld), .io_chk_data_o(io_dat), .ld_active_o(ld_act), .card_state_o(st));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] chk_word(input logic [7:0] c);
    return c[0] ? 16'h0055 : 16'h00AA;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic die(input bit k);
    if (!k) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h timeout", $time, 1'b0, 1'b1);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] x;
    bit k;
    host.xfer(1'b1, i, d, x, k);
    die(k);
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] x;
    bit k;
    host.xfer(1'b0, i, 8'h00, x, k);
    die(k);
    chk({8'h00, x}, {8'h00, e});
  endtask

  task automatic sc(input pnpcr_state_t e);
    #1;
    chk({14'h0000, st}, {14'h0000, e});
  endtask

  task automatic probe(input logic [15:0] a, input logic [1:0] s, input logic v, input logic [15:0] d);
    @(posedge clk_i);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({14'h0000, io_sel}, {14'h0000, s});
    chk({15'h0000, io_vld}, {15'h0000, v});
    if (v) chk(io_dat, d);
    @(posedge clk_i);
    io_rd <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(88));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(IDX_CSN, 8'h00);
    rc(IDX_CTRL, 8'h00);
    rc(8'h40, 8'h00);
    sc(ST_WAIT_KEY);
    $display("test reset done");
    card_select_value = 8'($urandom_range(255, 2));
    wr(IDX_KEY, 8'h00);
    wr(IDX_CSN, card_select_value);
    rc(IDX_CSN, card_select_value);
    wr(IDX_WAKE, card_select_value ^ 8'h01);
    sc(ST_SLEEP);
    wr(IDX_WAKE, card_select_value);
    sc(ST_CONFIG);
    $display("test wake done");
    for (int k = 0; k < 11; k++) begin
      host.rsrc(b[k], ok);
      die(ok);
    end
    chk({8'h00, b[10]}, 16'h0079);
    rc(IDX_STATUS, 8'h01);
    wr(IDX_WAKE, card_select_value);
    host.rsrc(q, ok);
    die(ok);
    chk({8'h00, q}, {8'h00, b[0]});
    host.rsrc(q, ok);
    die(ok);
    chk({8'h00, q}, {8'h00, b[1]});
    $display("test resource done");
    for (int l = 0; l < 2; l++) begin
      wr(IDX_LDN, 8'(l));
      for (int j = 0; j < 2; j++) begin
        base[l][j] = {1'(l), 1'b1, 6'($urandom), 8'($urandom) & 8'hF0};
        wr(IDX_B0_HI + 8'(2 * j), base[l][j][15:8]);
        wr(IDX_B0_LO + 8'(2 * j), base[l][j][7:0]);
      end
      wr(IDX_CHK, 8'hFF);
    end
    for (int l = 0; l < 2; l++) begin
      wr(IDX_LDN, 8'(l));
      rc(IDX_LDN, 8'(l));
      rc(IDX_B0_HI, base[l][0][15:8]);
      rc(IDX_B0_LO, base[l][0][7:0]);
      rc(IDX_B1_HI, base[l][1][15:8]);
      rc(IDX_B1_LO, base[l][1][7:0]);
      rc(IDX_CHK, 8'h03);
    end
    $display("test descriptors done");
    probe(base[1][1] + 16'h0007, 2'b10, 1'b1, chk_word(8'h03));
    wr(IDX_CHK, 8'h02);
    probe(base[1][0], 2'b10, 1'b1, chk_word(8'h02));
    probe(16'h0010, 2'b00, 1'b0, 16'h0000);
    host.activate(8'hFF, ok);
    die(ok);
    rc(IDX_ACT, 8'h01);
    #1 chk({14'h0000, ld_act}, 16'h0002);
    wr(IDX_CHK, 8'h03);
    probe(base[1][0], 2'b10, 1'b0, 16'h0000);
    probe(base[0][1] + 16'h0004, 2'b01, 1'b1, chk_word(8'h03));
    $display("test range check done");
    wr(IDX_CTRL, 8'h02);
    sc(ST_WAIT_KEY);
    chk({14'h0000, ld_act}, 16'h0002);
    rc(IDX_CSN, card_select_value);
    wr(IDX_KEY, 8'h00);
    sc(ST_SLEEP);
    wr(IDX_CTRL, 8'h01);
    #1 chk({14'h0000, ld_act}, 16'h0000);
    rc(IDX_CSN, card_select_value);
    rc(IDX_LDN, 8'h00);
    rc(IDX_B0_HI, 8'h00);
    wr(IDX_CTRL, 8'h04);
    rc(IDX_CSN, 8'h00);
    wr(IDX_WAKE, 8'h00);
    sc(ST_ISOLATE);
    rc(IDX_STATE, 8'h02);
    wr(IDX_WAKE, 8'h01);
    sc(ST_SLEEP);
    wr(IDX_LDN, 8'h05);
    rc(IDX_LDN, 8'h05);
    wr(IDX_B0_HI, 8'hFF);
    rc(IDX_B0_HI, 8'h00);
    wr(IDX_LDN, 8'h00);
    rc(IDX_B0_HI, 8'h00);
    $display("test control done");
    results();
  end
endmodule
